// [rtl/mpc_top.sv]
// power-up handshake sequencer for the module side
`timescale 1ns/1ns
`default_nettype none
module mpc_top
  import mpc_pkg::*;
#(
  parameter int SETTLE_CYC = MPC_SETTLE_CYC
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic power_good_in,
  input wire logic power_button_request_n,
  input wire logic button_toggle_en,
  input wire logic button_wake_en,
  output logic suspend_rail_on_n,
  output logic seq_running,
  output logic seq_done
);
  mpc_sync_if sync ();
  mpc_state_t state;
  mpc_state_t next_state;
  logic [MPC_CNT_W-1:0] cnt;
  logic [MPC_CNT_W-1:0] next_cnt;
  logic btn_d;
  logic rail_n;
  logic next_rail_n;
  logic running;
  logic next_running;
  logic done;
  logic next_done;
  logic press;

  mpc_sync u_sync (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .power_good_in(power_good_in),
    .power_button_request_n(power_button_request_n),
    .sync(sync)
  );

  // button acts on its press edge only, holding it does nothing more
  assign press = sync.button & ~btn_d;

  // rail stays requested through settle so the supply ramps before the module runs
  function automatic logic rail_wanted(input mpc_state_t s);
    return (s == MPC_SETTLE) || (s == MPC_ON);
  endfunction

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      MPC_OFF:
      begin
        if (sync.good)
        begin
          next_state = MPC_ARMED;
        end
      end
      MPC_ARMED:
      begin
        // wake policy comes from firmware straps, no hardwired action
        if (!sync.good)
        begin
          next_state = MPC_OFF;
        end
        else if (button_wake_en && press)
        begin
          next_state = MPC_SETTLE;
          next_cnt = '0;
        end
        else if (!button_wake_en)
        begin
          next_state = MPC_SETTLE;
          next_cnt = '0;
        end
      end
      MPC_SETTLE:
      begin
        if (!sync.good)
        begin
          next_state = MPC_OFF;
        end
        else if (cnt == MPC_CNT_W'(SETTLE_CYC - 1))
        begin
          next_state = MPC_ON;
        end
        else
        begin
          next_cnt = cnt + 1'b1;
        end
      end
      MPC_ON:
      begin
        if (!sync.good)
        begin
          next_state = MPC_OFF;
        end
        else if (button_toggle_en && press)
        begin
          next_state = MPC_ARMED;
        end
      end
      default:
      begin
        next_state = MPC_OFF;
      end
    endcase
    next_rail_n = !rail_wanted(next_state);
    next_running = (next_state == MPC_SETTLE);
    next_done = (next_state == MPC_ON);
  end

  // rail output registered so glitches never reach the supply
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state <= MPC_OFF;
      cnt <= '0;
      btn_d <= 1'b0;
      rail_n <= MPC_RAIL_OFF_N;
      running <= 1'b0;
      done <= 1'b0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      cnt <= next_cnt;
      btn_d <= sync.button;
      rail_n <= next_rail_n;
      running <= next_running;
      done <= next_done;
    end
  end

  assign suspend_rail_on_n = rail_n;
  assign seq_running = running;
  assign seq_done = done;

  sequence good_low_s;
    !sync.good;
  endsequence

  off_while_low_a: assert property (@(posedge mclk) disable iff (reset)
    good_low_s ##1 clk_en |=> suspend_rail_on_n)
    else $error("rail on while power good low");

  start_needs_good_a: assert property (@(posedge mclk) disable iff (reset)
    $fell(suspend_rail_on_n) |-> $past(sync.good))
    else $error("rail came on without power good");

  // limitation: a low clk_en inside settle stretches the phase past this bound
  settle_len_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(seq_running) |-> ##[1:SETTLE_CYC] !seq_running)
    else $error("settle phase overran");

  done_rail_a: assert property (@(posedge mclk) disable iff (reset)
    seq_done |-> !suspend_rail_on_n)
    else $error("done but rail off");

  toggle_off_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && state == MPC_ON && sync.good && button_toggle_en && press |=> !seq_done)
    else $error("button did not turn power off");

  no_toggle_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && state == MPC_ON && sync.good && !button_toggle_en |=> seq_done)
    else $error("power dropped with toggle disabled");

  // clk_en in each antecedent, a frozen block may hold any state
  sequence settle_mid_s;
    clk_en && sync.good && state == MPC_SETTLE && cnt != MPC_CNT_W'(SETTLE_CYC - 1);
  endsequence

  sequence settle_last_s;
    clk_en && sync.good && state == MPC_SETTLE && cnt == MPC_CNT_W'(SETTLE_CYC - 1);
  endsequence

  sequence wake_press_s;
    clk_en && sync.good && state == MPC_ARMED && button_wake_en && press;
  endsequence

  settle_hold_a: assert property (@(posedge mclk) disable iff (reset)
    settle_mid_s |=> seq_running && !suspend_rail_on_n)
    else $error("settle phase left early");

  settle_end_a: assert property (@(posedge mclk) disable iff (reset)
    settle_last_s |=> seq_done && !seq_running && !suspend_rail_on_n)
    else $error("settle did not reach on");

  wake_start_a: assert property (@(posedge mclk) disable iff (reset)
    wake_press_s |=> seq_running && !suspend_rail_on_n)
    else $error("press did not start sequencing");

  wake_wait_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && state == MPC_ARMED && sync.good && button_wake_en && !press
    |=> suspend_rail_on_n)
    else $error("rail on without wake press");

  auto_on_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && state == MPC_ARMED && sync.good && !button_wake_en
    |=> seq_running && !suspend_rail_on_n)
    else $error("auto start did not begin");

  off_stays_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && state == MPC_OFF && !sync.good |=> state == MPC_OFF && suspend_rail_on_n)
    else $error("left off state without power good");
endmodule // mpc_top
`default_nettype wire

// [rtl/mpc_pkg.sv]
// constants and types shared by the module power control block
package mpc_pkg;
  localparam int MPC_SYNC_STAGES = 3;
  localparam int MPC_CLK_MHZ = 100;
  localparam int MPC_SETTLE_US = 10;
  localparam int MPC_SETTLE_CYC = MPC_SETTLE_US * MPC_CLK_MHZ;
  localparam int MPC_CNT_W = 16;
  localparam logic MPC_RAIL_OFF_N = 1'b1;
  typedef enum logic [3:0] {
    MPC_OFF = 4'h1,
    MPC_ARMED = 4'h2,
    MPC_SETTLE = 4'h4,
    MPC_ON = 4'h8
  } mpc_state_t;
endpackage

// [rtl/mpc_sync_if.sv]
// synchronised input levels passed from the front end to the sequencer
`timescale 1ns/1ns
`default_nettype none
interface mpc_sync_if;
  logic good;
  logic button;
  modport front (output good, output button);
  modport seq (input good, input button);
endinterface
`default_nettype wire

// [rtl/mpc_sync.sv]
// three-stage synchronisers for power good and power button
`timescale 1ns/1ns
`default_nettype none
module mpc_sync
  import mpc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic power_good_in,
  input wire logic power_button_request_n,
  mpc_sync_if.front sync
);
  logic [MPC_SYNC_STAGES-1:0] good_sr;
  logic [MPC_SYNC_STAGES-1:0] btn_sr;
  logic [MPC_SYNC_STAGES-1:0] next_good_sr;
  logic [MPC_SYNC_STAGES-1:0] next_btn_sr;
  logic good_q;
  logic btn_q;
  logic next_good_q;
  logic next_btn_q;

  // a change counts only once the last two stages agree
  always_comb
  begin
    next_good_sr = {good_sr[MPC_SYNC_STAGES-2:0], power_good_in};
    next_btn_sr = {btn_sr[MPC_SYNC_STAGES-2:0], ~power_button_request_n};
    next_good_q = good_q;
    next_btn_q = btn_q;
    if (good_sr[1] == good_sr[2])
    begin
      next_good_q = good_sr[2];
    end
    if (btn_sr[1] == btn_sr[2])
    begin
      next_btn_q = btn_sr[2];
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      good_sr <= '0;
      btn_sr <= '0;
      good_q <= 1'b0;
      btn_q <= 1'b0;
    end
    else if (clk_en)
    begin
      good_sr <= next_good_sr;
      btn_sr <= next_btn_sr;
      good_q <= next_good_q;
      btn_q <= next_btn_q;
    end
  end

  agree_only_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && good_sr[1] != good_sr[2] |=> $stable(good_q))
    else $error("power good taken before stages agree");

  assign sync.good = good_q;
  assign sync.button = btn_q;
endmodule // mpc_sync
`default_nettype wire

// [testbench/mpc_carrier.sv]
// carrier model: supply, delayed power good, push button
`timescale 1ns/1ns
`default_nettype none
module mpc_carrier
#(
  parameter int DELAY = 8
)
(
  input wire logic mclk,
  input wire logic rails_up,
  input wire logic press,
  input wire logic suspend_rail_on_n,
  output logic power_good_in,
  output logic power_button_request_n,
  output logic main_on
);
  int cnt = 0;
  // standby-powered inverter ahead of the supply
  assign main_on = ~suspend_rail_on_n;
  // grounded debounced contact, pulled up while released
  assign power_button_request_n = press ? 1'b0 : 1'b1;
  // delay is scaled down from the long carrier wait to keep runs short
  always @(posedge mclk)
    cnt <= rails_up ? (cnt < DELAY ? cnt + 1 : cnt) : 0;
  assign power_good_in = (cnt == DELAY);
endmodule // mpc_carrier
`default_nettype wire

// [testbench/tb_module_power_control.sv]
// testbench for the module power control sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_module_power_control;
  import mpc_pkg::*;
  localparam int SET = 4;
  logic mclk = 1'b0, reset = 1'b1, clk_en = 1'b1, rails_up = 1'b0, press = 1'b0;
  logic tog = 1'b0, wake = 1'b0;
  logic pg, pb_n, rail_n, run, done, main_on;
  int n_mismatch = 0, checked = 0, k;
  integer seed = 32'h9c8c54e2;
  mpc_top #(.SETTLE_CYC(SET)) u_dut (.mclk(mclk), .reset(reset), .clk_en(clk_en),
    .power_good_in(pg), .power_button_request_n(pb_n), .button_toggle_en(tog),
    .button_wake_en(wake), .suspend_rail_on_n(rail_n), .seq_running(run), .seq_done(done));
  mpc_carrier u_car (.mclk(mclk), .rails_up(rails_up), .press(press),
    .suspend_rail_on_n(rail_n), .power_good_in(pg), .power_button_request_n(pb_n),
    .main_on(main_on));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // expected {rail_n, run, done}
  function automatic logic [31:0] outs(input logic on, input logic set);
    return {29'h0, ~(on | set), set, on};
  endfunction
  function automatic logic [31:0] cur();
    return {29'h0, rail_n, run, done};
  endfunction
  // bounded wait for settle, then its length and the on state
  task automatic settle();
    k = 0;
    while (run !== 1'b1 && k < 60)
    begin
      @(negedge mclk);
      k++;
    end
    cmp(cur(), outs(0, 1));
    k = 0;
    while (run === 1'b1 && k < 60)
    begin
      @(negedge mclk);
      k++;
    end
    cmp(k, SET);
    cmp(cur(), outs(1, 0));
  endtask
  task tally_and_finish();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
    forever #5 mclk = ~mclk;
  initial
  begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    // chatter on the button must not wake a block without power good
    repeat (60) @(posedge mclk) press <= 1'($random(seed));
    @(negedge mclk);
    cmp(cur(), outs(0, 0));
    @(posedge mclk) press <= 1'b0;
    rails_up <= 1'b1;
    settle();
    @(posedge mclk) press <= 1'b1;
    repeat (12) @(negedge mclk);
    cmp(cur(), outs(1, 0));
    @(posedge mclk) press <= 1'b0;
    tog <= 1'b1;
    repeat (8) @(posedge mclk);
    press <= 1'b1;
    settle();
    @(posedge mclk) press <= 1'b0;
    rails_up <= 1'b0;
    repeat (8) @(negedge mclk);
    cmp(cur(), outs(0, 0));
    @(posedge mclk) wake <= 1'b1;
    rails_up <= 1'b1;
    repeat (30) @(negedge mclk);
    cmp(cur(), outs(0, 0));
    @(posedge mclk) press <= 1'b1;
    settle();
    cmp({31'h0, main_on}, 32'h1);
    // a second reset with the block on drops the rail at once
    @(posedge mclk) reset <= 1'b1;
    press <= 1'b0;
    repeat (3) @(negedge mclk);
    cmp(cur(), outs(0, 0));
    @(posedge mclk) reset <= 1'b0;
    repeat (8) @(negedge mclk);
    cmp(cur(), outs(0, 0));
    @(posedge mclk) press <= 1'b1;
    settle();
    // frozen clock enable hides the power good drop until it is raised
    @(posedge mclk) clk_en <= 1'b0;
    rails_up <= 1'b0;
    repeat (12) @(negedge mclk);
    cmp(cur(), outs(1, 0));
    @(posedge mclk) clk_en <= 1'b1;
    repeat (8) @(negedge mclk);
    cmp(cur(), outs(0, 0));
    tally_and_finish();
  end
endmodule // tb_module_power_control
`default_nettype wire
